//--- logic/phi_board.sv
// panel host interface board: host port, leds, display path, inputs
// assumes host strobes are one cycle, synchronous to mclk_i
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module phi_board #(
    parameter int KA_PERIOD_CYC = phi_pkg::KA_PERIOD_CYC
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    // host port
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic             wait_o,
    output logic             irq_o,
    // panel output lines and return input
    output logic      [15:0] panel_data_o,
    output logic      [3:0]  panel_ctl_o,
    input  wire logic        panel_ret_i,
    // switches and leds
    input  wire logic [7:0]  sw_n_i,
    input  wire logic [7:0]  mode_i,
    output logic      [7:0]  led_yel_o,
    output logic      [7:0]  led_red_o,
    output logic             led_ka_n_o,
    // display controller
    output logic      [7:0]  disp_data_o,
    output logic             disp_wr_o,
    output logic             disp_clr_o,
    output logic             disp_clk_o,
    output logic             mcu_irq_o,
    // touch serial line
    input  wire logic        touch_rx_i
);
    typedef struct packed {
        logic [15:0] rdata;
        logic        wt;
        logic        irq;
        logic [15:0] pdata;
        logic [3:0]  pctl;
        logic [7:0]  yel;
        logic [7:0]  red;
        logic        ka_n;
        logic [16:0] ka_cnt;
        logic [7:0]  ddata;
        logic        dwr;
        logic        dclr;
        logic        dclk;
        logic [3:0]  dcnt;
        logic        mirq;
        logic [7:0]  sw_prev;
        logic [7:0]  sw_stat;
        logic        pend;
    } phi_st_s;

    phi_st_s             st_reg;
    phi_st_s             st_next;
    phi_pkg::phi_req_s   req;
    phi_pkg::phi_touch_s touch;
    logic [11:0]         dly_taps;
    logic [17:0]         sync_taps;
    logic [7:0]          sw_now;
    logic                rx_now;
    logic                over;
    logic                touch_rd;
    logic [7:0]          accept;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign touch_rd = req.rd && (req.addr == phi_pkg::A_TOUCH_X || req.addr == phi_pkg::A_TOUCH_Y);

    phi_pipe #(
        .W      (9),
        .STAGES (phi_pkg::SYNC_STAGES)
    ) u_sync (
        .clk_i  (mclk_i),
        .rstn_i (rstn_i),
        .d_i    ({touch_rx_i, ~sw_n_i}),
        .taps_o (sync_taps)
    );
    // switches stored pressed-high: a cleared stage reads as idle, no false press after reset
    assign sw_now = ~sync_taps[16:9];
    assign rx_now = sync_taps[17];

    // four-stage delay of access, display write and clear
    phi_pipe #(
        .W      (3),
        .STAGES (phi_pkg::DLY_STAGES)
    ) u_dly (
        .clk_i  (mclk_i),
        .rstn_i (rstn_i),
        .d_i    ({req.wr && req.addr == phi_pkg::A_DISP_CLR,
                  req.wr && req.addr == phi_pkg::A_DISP_DATA,
                  req.wr || req.rd}),
        .taps_o (dly_taps)
    );

    phi_touch_rx u_rx (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .rx_i   (rx_now),
        .clr_i  (touch_rd),
        .over_o (over),
        .data_o (touch)
    );

    // falling edge of each synchronised switch
    // unsuggested presses refused while one is pending
    assign accept = st_reg.sw_prev & ~sw_now & (st_reg.yel | {8{~st_reg.pend}});

    // single control process for every strobe and flag
    always_comb begin
        st_next         = st_reg;
        st_next.sw_prev = sw_now;
        if (req.wr && req.addr == phi_pkg::A_LED_SET) begin
            st_next.yel = st_reg.yel | req.wdata[7:0];
        end
        if (req.wr && req.addr == phi_pkg::A_LED_CLR) begin
            st_next.yel = st_reg.yel & ~req.wdata[7:0];
            st_next.red = st_reg.red & ~req.wdata[15:8];
        end
        if (req.wr && req.addr == phi_pkg::A_PANEL_OUT) begin
            st_next.pdata = req.wdata;
        end
        if (req.wr && req.addr == phi_pkg::A_DISP_CLR) begin
            st_next.pctl = req.wdata[3:0];
        end
        // display byte held for the controller port
        if (req.wr && req.addr == phi_pkg::A_DISP_DATA) begin
            st_next.ddata = req.wdata[7:0];
        end
        // strobes from taps, controller interrupt last
        st_next.wt   = |{dly_taps[9], dly_taps[6], dly_taps[3], dly_taps[0]};
        st_next.dwr  = dly_taps[4] | dly_taps[7];
        st_next.dclr = dly_taps[5] | dly_taps[8];
        st_next.mirq = dly_taps[10];
        // keep-alive low pulse on the led line
        st_next.ka_cnt = (st_reg.ka_cnt == 17'(KA_PERIOD_CYC - 1)) ? 17'h00000 : st_reg.ka_cnt + 17'h00001;
        // pulse sits at the period end, so the line is high out of reset and every pulse is full width
        st_next.ka_n   = st_next.ka_cnt < 17'(KA_PERIOD_CYC - phi_pkg::KA_LOW_CYC);
        if (st_reg.dcnt == 4'(phi_pkg::DISP_HALF - 1)) begin
            st_next.dcnt = 4'h0;
            st_next.dclk = !st_reg.dclk;
        end else begin
            st_next.dcnt = st_reg.dcnt + 4'h1;
        end
        // read releases the latch; a new press wins
        if (req.rd && req.addr == phi_pkg::A_SW_STAT) begin
            st_next.sw_stat = 8'h00;
            st_next.pend    = 1'b0;
        end
        if (|accept) begin
            st_next.sw_stat = st_next.sw_stat | accept;
            st_next.red     = st_next.red | accept;
            st_next.pend    = 1'b1;
        end
        // host interrupt from frame or press
        st_next.irq = over | st_reg.pend;
        // read source decode, data one cycle later
        st_next.rdata = 16'h0000;
        if (req.rd) begin
            case (req.addr)
                phi_pkg::A_LED_SET: st_next.rdata = {st_reg.red, st_reg.yel};
                phi_pkg::A_SW_STAT: st_next.rdata = {8'h00, st_reg.sw_stat};
                phi_pkg::A_MODE:    st_next.rdata = {8'h00, mode_i};
                phi_pkg::A_TOUCH_X: st_next.rdata = {2'h0, touch.x};
                phi_pkg::A_TOUCH_Y: st_next.rdata = {2'h0, touch.y};
                phi_pkg::A_STATUS: begin
                    st_next.rdata[phi_pkg::ST_OVER] = over;
                    st_next.rdata[phi_pkg::ST_PEND] = st_reg.pend;
                    st_next.rdata[phi_pkg::ST_RET]  = panel_ret_i;
                end
                default:            st_next.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_reg        <= '0;
            st_reg.ka_n   <= 1'b1;
            st_reg.sw_prev <= 8'hFF;
            st_reg.rdata  <= phi_pkg::RDATA_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from state
    assign rdata_o      = st_reg.rdata;
    assign wait_o       = st_reg.wt;
    assign irq_o        = st_reg.irq;
    assign panel_data_o = st_reg.pdata;
    assign panel_ctl_o  = st_reg.pctl;
    assign led_yel_o    = st_reg.yel;
    assign led_red_o    = st_reg.red;
    assign led_ka_n_o   = st_reg.ka_n;
    assign disp_data_o  = st_reg.ddata;
    assign disp_wr_o    = st_reg.dwr;
    assign disp_clr_o   = st_reg.dclr;
    assign disp_clk_o   = st_reg.dclk;
    assign mcu_irq_o    = st_reg.mirq;

    // checks
    property p_wait;
        @(posedge mclk_i) disable iff (!rstn_i) (wr_i || rd_i) |-> ##2 wait_o [*4];
    endproperty
    a_wait: assert property (p_wait) else $error("wait not held four cycles");
    property p_led_set;
        @(posedge mclk_i) disable iff (!rstn_i)
            (wr_i && addr_i == phi_pkg::A_LED_SET) |=> ((led_yel_o & $past(wdata_i[7:0])) == $past(wdata_i[7:0]));
    endproperty
    a_led_set: assert property (p_led_set) else $error("led set lost");
    property p_led_clr;
        @(posedge mclk_i) disable iff (!rstn_i)
            (wr_i && addr_i == phi_pkg::A_LED_CLR) |=> ((led_yel_o & $past(wdata_i[7:0])) == 8'h00);
    endproperty
    a_led_clr: assert property (p_led_clr) else $error("led clear lost");
    property p_ka;
        @(posedge mclk_i) disable iff (!rstn_i) $fell(led_ka_n_o) |-> ##24 !led_ka_n_o ##1 led_ka_n_o;
    endproperty
    a_ka: assert property (p_ka) else $error("keep-alive low width wrong");
    property p_dclk;
        @(posedge mclk_i) disable iff (!rstn_i) $rose(disp_clk_o) |-> ##13 disp_clk_o ##1 !disp_clk_o;
    endproperty
    a_dclk: assert property (p_dclk) else $error("display clock half period wrong");
    property p_mode;
        @(posedge mclk_i) disable iff (!rstn_i) (rd_i && addr_i == phi_pkg::A_MODE) |=> rdata_o[7:0] == $past(mode_i);
    endproperty
    a_mode: assert property (p_mode) else $error("mode read altered");
    property p_over_irq;
        @(posedge mclk_i) disable iff (!rstn_i) $rose(over) |=> irq_o;
    endproperty
    a_over_irq: assert property (p_over_irq) else $error("frame gave no interrupt");
    property p_over_clr;
        @(posedge mclk_i) disable iff (!rstn_i) (touch_rd && over) |=> !over;
    endproperty
    a_over_clr: assert property (p_over_clr) else $error("frame flag not cleared");
    property p_press;
        @(posedge mclk_i) disable iff (!rstn_i) (|accept) |=> st_reg.pend && ((led_red_o & $past(accept)) == $past(accept)) ##1 irq_o;
    endproperty
    a_press: assert property (p_press) else $error("press not latched");
    property p_block;
        @(posedge mclk_i) disable iff (!rstn_i)
            st_reg.pend |=> ((led_red_o & ~$past(led_red_o) & ~$past(led_yel_o)) == 8'h00);
    endproperty
    a_block: assert property (p_block) else $error("unsuggested press accepted");
    c_frame: cover property (@(posedge mclk_i) disable iff (!rstn_i) $rose(over));
    c_press: cover property (@(posedge mclk_i) disable iff (!rstn_i) |accept);
    c_disp:  cover property (@(posedge mclk_i) disable iff (!rstn_i) disp_wr_o ##[1:4] mcu_irq_o);
endmodule

//--- logic/phi_pkg.sv
// constants and carriers of the panel host interface board
// assumes a 125 MHz system clock and a host port one word wide
package phi_pkg;
    // clock
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_PS = 8000;
    // host port offsets (word addresses)
    localparam logic [3:0] A_LED_SET   = 4'h0;
    localparam logic [3:0] A_LED_CLR   = 4'h1;
    localparam logic [3:0] A_DISP_DATA = 4'h2;
    localparam logic [3:0] A_DISP_CLR  = 4'h3;
    localparam logic [3:0] A_PANEL_OUT = 4'h4;
    localparam logic [3:0] A_SW_STAT   = 4'h5;
    localparam logic [3:0] A_MODE      = 4'h6;
    localparam logic [3:0] A_TOUCH_X   = 4'h7;
    localparam logic [3:0] A_TOUCH_Y   = 4'h8;
    localparam logic [3:0] A_STATUS    = 4'h9;
    // status field positions
    localparam int ST_OVER  = 0;
    localparam int ST_PEND  = 1;
    localparam int ST_RET   = 2;
    // panel output word layout
    localparam int PANEL_CTL_LSB = 16;
    // keep-alive low pulse and its period
    localparam int KA_LOW_NS     = 200;
    localparam int KA_PERIOD_US  = 800;
    localparam int KA_LOW_CYC    = (KA_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int KA_PERIOD_CYC = (KA_PERIOD_US * 1_000_000) / CLK_PS;
    // touch receiver: sub tick, divide-by-16, 40 strobes a frame
    localparam int SUB_NS       = 100;
    localparam int SUB_CYC      = (SUB_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int DIV_STEPS    = 16;
    localparam int FRAME_BITS   = 40;
    // access delay line and input synchroniser depth
    localparam int DLY_STAGES   = 4;
    localparam int SYNC_STAGES  = 2;
    // display clock
    localparam int DISP_HZ      = 4_500_000;
    localparam int DISP_HALF    = (CLK_HZ + DISP_HZ) / (2 * DISP_HZ);
    // reset values
    localparam logic [15:0] RDATA_RST = 16'h0000;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } phi_req_s;

    typedef struct packed {
        logic [13:0] x;
        logic [13:0] y;
    } phi_touch_s;
endpackage

//--- logic/phi_pipe.sv
// plain shift pipeline: synchroniser or tapped delay line
// assumes one clock; taps_o holds every stage, stage 0 lowest
`timescale 1ns/10ps
module phi_pipe #(
    parameter int W      = 1,
    parameter int STAGES = 2
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    // data
    input  wire logic [W-1:0]        d_i,
    output logic      [W*STAGES-1:0] taps_o
);
    typedef struct packed {
        logic [W*STAGES-1:0] pipe;
    } phi_pipe_s;

    phi_pipe_s st_reg;
    phi_pipe_s st_next;

    // shift one stage per edge
    always_comb begin
        st_next      = st_reg;
        st_next.pipe = {st_reg.pipe[W*STAGES-W-1:0], d_i};
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign taps_o = st_reg.pipe;
endmodule

//--- logic/phi_touch_rx.sv
// touch panel frame receiver: four 10-bit words, one frame flag
// assumes rx_i already synchronised; idle line is low
`timescale 1ns/10ps
module phi_touch_rx (
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    // serial line and host clear
    input  wire logic              rx_i,
    input  wire logic              clr_i,
    // frame out
    output logic                   over_o,
    output phi_pkg::phi_touch_s    data_o
);
    typedef struct packed {
        logic        prev;
        logic        run;
        logic [3:0]  sub;
        logic [3:0]  div;
        logic [5:0]  bits;
        logic [39:0] sh;
        logic        over;
    } phi_rx_s;

    phi_rx_s st_reg;
    phi_rx_s st_next;
    logic    tick;
    logic    strobe;

    always_comb begin
        st_next      = st_reg;
        st_next.prev = rx_i;
        tick   = st_reg.run && (st_reg.sub == 4'(phi_pkg::SUB_CYC - 1));
        strobe = tick && (st_reg.div == 4'(phi_pkg::DIV_STEPS - 1));
        // host read drops the flag; a same-cycle set below wins
        if (clr_i) begin
            st_next.over = 1'b0;
        end
        if (!st_reg.run && !st_reg.over && rx_i && !st_reg.prev) begin
            st_next.run  = 1'b1;
            st_next.sub  = 4'h0;
            st_next.div  = 4'h0;
            st_next.bits = 6'h00;
        end
        if (st_reg.run) begin
            st_next.sub = tick ? 4'h0 : st_reg.sub + 4'h1;
            if (tick) begin
                st_next.div = st_reg.div + 4'h1;
            end
        end
        if (strobe) begin
            st_next.sh   = {rx_i, st_reg.sh[39:1]};
            st_next.bits = st_reg.bits + 6'h01;
            // frame done, timing back to rest
            if (st_reg.bits == 6'(phi_pkg::FRAME_BITS - 1)) begin
                st_next.over = 1'b1;
                st_next.run  = 1'b0;
                st_next.bits = 6'h00;
                st_next.sub  = 4'h0;
                st_next.div  = 4'h0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // two syncs then twelve data bits per axis
    assign data_o.x = {st_reg.sh[2:1], st_reg.sh[8:3], st_reg.sh[18:13]};
    assign data_o.y = {st_reg.sh[22:21], st_reg.sh[28:23], st_reg.sh[38:33]};
    assign over_o   = st_reg.over;
endmodule

//--- tb/phi_touch_ctl.sv
// touch controller model: sends one forty-bit frame on request
// assumes the caller starts send just after a clock edge
`timescale 1ns/10ps
module phi_touch_ctl #(
    parameter int BIT_CYC = 208
) (
    // clock
    input  wire logic mclk_i,
    // serial line, idle low
    output logic      rx_o
);
    initial rx_o = 1'b0;

    // four words back to back
    // first bit stretched by half a bit so every strobe after the first lands mid-bit
    task automatic send(input logic [39:0] v);
        for (int k = 0; k < 40; k++) begin
            rx_o <= v[k];
            repeat (k == 0 ? BIT_CYC + BIT_CYC / 2 : BIT_CYC) @(posedge mclk_i);
        end
        rx_o <= 1'b0;
    endtask
endmodule

//--- tb/phi_testbench.sv
// self-checking bench for the panel host interface board
// assumes phi_board in logic/ and the touch model in tb/
`timescale 1ns/10ps
module testbench;
    localparam int KA = 200;
    logic        mclk_i      = 1'b0;
    logic        rstn_i      = 1'b0;
    logic [3:0]  addr_i      = 4'h0;
    logic [15:0] wdata_i     = 16'h0000;
    logic        wr_i        = 1'b0;
    logic        rd_i        = 1'b0;
    logic        panel_ret_i = 1'b0;
    logic [7:0]  sw_n_i      = 8'hFF;
    logic [7:0]  mode_i      = 8'h00;
    logic        touch_rx_i;
    logic [15:0] rdata_o, panel_data_o;
    logic [7:0]  led_yel_o, led_red_o, disp_data_o;
    logic [3:0]  panel_ctl_o;
    logic        wait_o, irq_o, led_ka_n_o, disp_wr_o, disp_clr_o, disp_clk_o, mcu_irq_o;
    int          bad_count, n_checks, cyc, n_wait, n_dwr, n_dclr, n_mirq;
    int          dc_prev, dc_last, ka_prev, ka_fall, ka_low, irq_at, t0;
    logic        dclk_q, ka_q, irq_q;

    // 125 MHz clock
    always #4 mclk_i = ~mclk_i;

    phi_board #(.KA_PERIOD_CYC(KA)) dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wait_o(wait_o), .irq_o(irq_o),
        .panel_data_o(panel_data_o), .panel_ctl_o(panel_ctl_o), .panel_ret_i(panel_ret_i),
        .sw_n_i(sw_n_i), .mode_i(mode_i), .led_yel_o(led_yel_o), .led_red_o(led_red_o),
        .led_ka_n_o(led_ka_n_o), .disp_data_o(disp_data_o), .disp_wr_o(disp_wr_o),
        .disp_clr_o(disp_clr_o), .disp_clk_o(disp_clk_o), .mcu_irq_o(mcu_irq_o),
        .touch_rx_i(touch_rx_i)
    );

    phi_touch_ctl tp (.mclk_i(mclk_i), .rx_o(touch_rx_i));

    // pulse counts and edge stamps, sampled before the edge updates land
    always @(posedge mclk_i) begin
        cyc++;
        if (wait_o === 1'b1) n_wait++;
        if (disp_wr_o === 1'b1) n_dwr++;
        if (disp_clr_o === 1'b1) n_dclr++;
        if (mcu_irq_o === 1'b1) n_mirq++;
        if (disp_clk_o === 1'b1 && dclk_q === 1'b0) begin
            dc_prev = dc_last;
            dc_last = cyc;
        end
        if (led_ka_n_o === 1'b0 && ka_q === 1'b1) begin
            ka_prev = ka_fall;
            ka_fall = cyc;
        end
        if (led_ka_n_o === 1'b1 && ka_q === 1'b0) ka_low = cyc - ka_fall;
        if (irq_o === 1'b1 && irq_q === 1'b0) irq_at = cyc;
        dclk_q = disp_clk_o;
        ka_q = led_ka_n_o;
        irq_q = irq_o;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one-cycle host strobes, changed just after an edge
    task automatic host_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
        n_wait = 0;
        n_dwr = 0;
        n_dclr = 0;
        n_mirq = 0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic press(input int i, input int n);
        @(posedge mclk_i);
        sw_n_i[i] <= 1'b0;
        repeat (n) @(posedge mclk_i);
        sw_n_i[i] <= 1'b1;
        settle(6);
    endtask

    function automatic logic [9:0] mkw(input logic [1:0] s, input logic [5:0] d);
        return {1'b0, d, s, 1'b1};
    endfunction

    task automatic t_reset;
        chk(16'(led_ka_n_o), 16'h0001);
        chk(16'(led_yel_o), 16'h0000);
        chk(16'(irq_o), 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_leds;
        host_wr(phi_pkg::A_LED_SET, 16'h00A5);
        settle(10);
        chk(16'(n_wait), 16'h0004);
        chk(16'(led_yel_o), 16'h00A5);
        host_wr(phi_pkg::A_LED_CLR, 16'h0005);
        host_wr(4'hF, 16'h00FF);
        settle(2);
        chk(16'(led_yel_o), 16'h00A0);
        rd_chk(phi_pkg::A_LED_SET, 16'h00A0);
        rd_chk(4'hF, 16'h0000);
        $display("test leds done");
    endtask

    task automatic t_panel;
        host_wr(phi_pkg::A_PANEL_OUT, 16'hBEEF);
        host_wr(phi_pkg::A_DISP_CLR, 16'h000A);
        settle(10);
        chk(panel_data_o, 16'hBEEF);
        chk(16'(panel_ctl_o), 16'h000A);
        chk(16'(n_dclr), 16'h0002);
        panel_ret_i <= 1'b1;
        rd_chk(phi_pkg::A_STATUS, 16'h0004);
        panel_ret_i <= 1'b0;
        $display("test panel done");
    endtask

    task automatic t_disp;
        host_wr(phi_pkg::A_DISP_DATA, 16'h1234);
        settle(10);
        chk(16'(disp_data_o), 16'h0034);
        chk(16'(n_dwr), 16'h0002);
        chk(16'(n_mirq), 16'h0001);
        chk(16'(dc_last - dc_prev), 16'h001C);
        $display("test display done");
    endtask

    task automatic t_mode;
        mode_i <= 8'h5A;
        rd_chk(phi_pkg::A_MODE, 16'h005A);
        mode_i <= 8'hA5;
        rd_chk(phi_pkg::A_MODE, 16'h00A5);
        chk(16'(irq_o), 16'h0000);
        settle(KA * 3);
        chk(16'(ka_low), 16'h0019);
        chk(16'(ka_fall - ka_prev), 16'(KA));
        $display("test mode and keep-alive done");
    endtask

    task automatic t_sw;
        host_wr(phi_pkg::A_LED_CLR, 16'hFFFF);
        host_wr(phi_pkg::A_LED_SET, 16'h0001);
        press(0, 10);
        chk(16'(led_red_o), 16'h0001);
        chk(16'(irq_o), 16'h0001);
        press(1, 4);
        chk(16'(led_red_o), 16'h0001);
        rd_chk(phi_pkg::A_SW_STAT, 16'h0001);
        settle(3);
        chk(16'(irq_o), 16'h0000);
        press(1, 4);
        chk(16'(led_red_o), 16'h0003);
        rd_chk(phi_pkg::A_SW_STAT, 16'h0002);
        $display("test switches done");
    endtask

    task automatic t_touch;
        logic [39:0] fa;
        fa = {mkw(2'b00, 6'h07), mkw(2'b01, 6'h3C), mkw(2'b11, 6'h15), mkw(2'b10, 6'h2B)};
        settle(3);
        t0 = cyc;
        tp.send(fa);
        settle(2);
        chk(16'(irq_o), 16'h0001);
        chk(16'(irq_at - t0 >= 8320 && irq_at - t0 <= 8332), 16'h0001);
        rd_chk(phi_pkg::A_STATUS, 16'h0001);
        tp.send({4{mkw(2'b11, 6'h3F)}});
        settle(2);
        rd_chk(phi_pkg::A_TOUCH_X, {4'h2, 6'h2B, 6'h15});
        rd_chk(phi_pkg::A_TOUCH_Y, {4'h1, 6'h3C, 6'h07});
        rd_chk(phi_pkg::A_STATUS, 16'h0000);
        chk(16'(irq_o), 16'h0000);
        $display("test touch done");
    endtask

    // watchdog against a hang
    initial begin
        #720000;
        bad_count++;
        report_and_stop();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        rstn_i <= 1'b1;
        settle(1);
        t_reset();
        t_leds();
        t_panel();
        t_disp();
        t_mode();
        t_sw();
        t_touch();
        report_and_stop();
    end
endmodule
